//--- logic/mcri_pkg.sv
`default_nettype none
package mcri_pkg;

  // ----------------------------------------------------------------
  // Command numbers
  // ----------------------------------------------------------------
  localparam logic [7:0] ROTATE_CW_CMD = 8'h01;
  localparam logic [7:0] ROTATE_CCW_CMD = 8'h02;
  localparam logic [7:0] MOTOR_HALT_CMD = 8'h03;
  localparam logic [7:0] MOVE_TO_TARGET_CMD = 8'h04;
  localparam logic [7:0] AXIS_PARAM_WRITE = 8'h05;
  localparam logic [7:0] AXIS_PARAM_READ = 8'h06;
  localparam logic [7:0] GLOBAL_PARAM_WRITE = 8'h09;
  localparam logic [7:0] GLOBAL_PARAM_READ = 8'h0a;
  localparam logic [7:0] GLOBAL_PARAM_SAVE = 8'h0b;
  localparam logic [7:0] GLOBAL_PARAM_RELOAD = 8'h0c;
  localparam logic [7:0] REF_SEARCH_CMD = 8'h0d;
  localparam logic [7:0] OUTPUT_WRITE_CMD = 8'h0e;
  localparam logic [7:0] INPUT_READ_CMD = 8'h0f;
  localparam logic [7:0] ACCU_CONST_OP = 8'h13;
  localparam logic [7:0] COMPARE_CMD = 8'h14;
  localparam logic [7:0] BRANCH_IF = 8'h15;
  localparam logic [7:0] BRANCH_ALWAYS = 8'h16;
  localparam logic [7:0] CALL_CMD = 8'h17;
  localparam logic [7:0] RETURN_CMD = 8'h18;
  localparam logic [7:0] INT_ON_CMD = 8'h19;
  localparam logic [7:0] INT_OFF_CMD = 8'h1a;
  localparam logic [7:0] WAIT_CMD = 8'h1b;
  localparam logic [7:0] END_CMD = 8'h1c;
  localparam logic [7:0] POINT_SET_CMD = 8'h1e;
  localparam logic [7:0] POINT_GET_CMD = 8'h1f;
  localparam logic [7:0] POINT_CAPT_CMD = 8'h20;
  localparam logic [7:0] ACCU_XREG_OP = 8'h21;
  localparam logic [7:0] ACCU_TO_AXIS_PARAM = 8'h22;
  localparam logic [7:0] ACCU_TO_GLOBAL_PARAM = 8'h23;
  localparam logic [7:0] FLAG_CLR_CMD = 8'h24;
  localparam logic [7:0] VEC_SET_CMD = 8'h25;
  localparam logic [7:0] INT_RET_CMD = 8'h26;
  localparam logic [7:0] ACCU_TO_POINT_CMD = 8'h27;

  // ----------------------------------------------------------------
  // Types, operations, conditions
  // ----------------------------------------------------------------
  localparam logic [7:0] ABSOLUTE_TARGET = 8'h00;
  localparam logic [7:0] RELATIVE_TARGET = 8'h01;
  localparam logic [7:0] STORED_POINT_TARGET = 8'h02;
  localparam logic [7:0] OP_ADD = 8'h00;
  localparam logic [7:0] OP_SUB = 8'h01;
  localparam logic [7:0] OP_MUL = 8'h02;
  localparam logic [7:0] OP_AND = 8'h05;
  localparam logic [7:0] OP_OR = 8'h06;
  localparam logic [7:0] OP_XOR = 8'h07;
  localparam logic [7:0] OP_NOT = 8'h08;
  localparam logic [7:0] OP_LOAD = 8'h09;
  localparam logic [7:0] CND_ZERO = 8'h00;
  localparam logic [7:0] CND_NZERO = 8'h01;
  localparam logic [7:0] CND_EQ = 8'h02;
  localparam logic [7:0] CND_NE = 8'h03;
  localparam logic [7:0] CND_GT = 8'h04;
  localparam logic [7:0] CND_GE = 8'h05;
  localparam logic [7:0] CND_LT = 8'h06;
  localparam logic [7:0] CND_LE = 8'h07;
  localparam logic [7:0] WAIT_TICKS = 8'h00;
  localparam logic [7:0] AXIS_COUNT = 8'h06;
  localparam logic [7:0] USER_VAR_BANK = 8'h02;

  // ----------------------------------------------------------------
  // Status codes
  // ----------------------------------------------------------------
  localparam logic [7:0] STS_OK = 8'h64;
  localparam logic [7:0] STS_STORED = 8'h65;
  localparam logic [7:0] STS_BAD_SUM = 8'h01;
  localparam logic [7:0] STS_BAD_CMD = 8'h02;
  localparam logic [7:0] STS_BAD_TYPE = 8'h03;
  localparam logic [7:0] STS_BAD_VALUE = 8'h04;
  localparam logic [7:0] STS_LOCKED = 8'h05;
  localparam logic [7:0] STS_NOT_AVAIL = 8'h06;

  // ----------------------------------------------------------------
  // Framing, program store, reset values
  // ----------------------------------------------------------------
  localparam logic [3:0] FRAME_LEN_SERIAL = 4'h9;
  localparam logic [3:0] FRAME_LEN_CAN = 4'h7;
  localparam logic [3:0] TX_FIRST_SERIAL = 4'h0;
  localparam logic [3:0] TX_FIRST_CAN = 4'h1;
  localparam logic [3:0] TX_LAST_SERIAL = 4'h8;
  localparam logic [3:0] TX_LAST_CAN = 4'h7;
  localparam logic [4:0] PROG_DEPTH = 5'h10;
  localparam logic [31:0] RESET_WORD = 32'h0;
  localparam logic [7:0] RESET_BYTE = 8'h0;

  typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_REPLY} mcri_state_e;

  typedef struct packed {
    mcri_state_e st;
    logic [71:0] rx_buf;
    logic [3:0] rx_cnt;
    logic [7:0] rx_sum;
    logic rx_ok;
    logic frm_rdy;
    logic [7:0] cmd;
    logic [7:0] typ;
    logic [7:0] bank;
    logic [31:0] val;
    logic [31:0] ex_val;
    logic from_prog;
    logic [7:0] status;
    logic [31:0] rval;
    logic exec_req;
    logic rep_start;
    logic [31:0] accu;
    logic [31:0] xreg;
    logic flag_eq;
    logic flag_lt;
    logic run_on;
    logic wait_on;
    logic [3:0] pc;
    logic [31:0] wait_cnt;
    logic [4:0] wptr;
    logic [15:0][55:0] prog;
  } mcri_main_s;

  typedef struct packed {
    logic active;
    logic can;
    logic [3:0] idx;
    logic [7:0] sum;
    logic [7:0] dat;
    logic [7:0] raddr;
    logic [7:0] maddr;
    logic [7:0] status;
    logic [7:0] cmd;
    logic [31:0] value;
  } mcri_tx_s;

endpackage
`default_nettype wire

//--- logic/mcri_reply_if.sv
`timescale 1ns/1ps
`default_nettype none
interface mcri_reply_if;
  logic start;
  logic can_mode;
  logic [7:0] reply_addr;
  logic [7:0] module_addr;
  logic [7:0] status;
  logic [7:0] cmd;
  logic [31:0] value;
  logic busy;
  modport src (output start, can_mode, reply_addr, module_addr, status,
               cmd, value, input busy);
  modport snk (input start, can_mode, reply_addr, module_addr, status,
               cmd, value, output busy);
endinterface
`default_nettype wire

//--- logic/mcri_reply_tx.sv
`timescale 1ns/1ps
`default_nettype none
module mcri_reply_tx
  import mcri_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  mcri_reply_if.snk rep,
  output logic [7:0] tx_data,
  output logic tx_valid,
  input wire logic tx_ready
);

  mcri_tx_s s_r;
  mcri_tx_s s_nxt;

  // ----------------------------------------------------------------
  // Byte selection
  // ----------------------------------------------------------------
  function automatic logic [7:0] byte_at(input mcri_tx_s t);
    case (t.idx)
      4'h0: byte_at = t.raddr;
      4'h1: byte_at = t.maddr;
      4'h2: byte_at = t.status;
      4'h3: byte_at = t.cmd;
      4'h4: byte_at = t.value[31:24];
      4'h5: byte_at = t.value[23:16];
      4'h6: byte_at = t.value[15:8];
      4'h7: byte_at = t.value[7:0];
      default: byte_at = t.sum;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    if (!s_r.active && rep.start) begin
      s_nxt.active = 1'b1;
      s_nxt.can = rep.can_mode;
      s_nxt.raddr = rep.reply_addr;
      s_nxt.maddr = rep.module_addr;
      s_nxt.status = rep.status;
      s_nxt.cmd = rep.cmd;
      s_nxt.value = rep.value;
      s_nxt.sum = RESET_BYTE;
      s_nxt.idx = rep.can_mode ? TX_FIRST_CAN : TX_FIRST_SERIAL;
      s_nxt.dat = byte_at(s_nxt);
    end else if (s_r.active && tx_ready) begin
      s_nxt.sum = s_r.sum + s_r.dat;
      if (s_r.idx == (s_r.can ? TX_LAST_CAN : TX_LAST_SERIAL)) begin
        s_nxt.active = 1'b0;
      end else begin
        s_nxt.idx = s_r.idx + 4'h1;
        s_nxt.dat = byte_at(s_nxt);
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign tx_data = s_r.dat;
  assign tx_valid = s_r.active;
  assign rep.busy = s_r.active | rep.start;

endmodule
`default_nettype wire

//--- logic/mcri_cmd_interp.sv
`timescale 1ns/1ps
`default_nettype none
module mcri_cmd_interp
  import mcri_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [7:0] rx_data,
  input wire logic rx_valid,
  output logic [7:0] tx_data,
  output logic tx_valid,
  input wire logic tx_ready,
  input wire logic can_mode,
  input wire logic [7:0] module_addr,
  input wire logic [7:0] reply_addr,
  input wire logic download_mode,
  input wire logic run_start,
  input wire logic tick_pulse,
  output logic exec_req,
  output logic [7:0] exec_cmd,
  output logic [7:0] exec_type,
  output logic [7:0] exec_bank,
  output logic [31:0] exec_value,
  output logic exec_from_prog,
  input wire logic exec_done,
  input wire logic [7:0] exec_status,
  input wire logic [31:0] exec_rdata,
  output logic run_active
);

  mcri_main_s s_r;
  mcri_main_s s_nxt;
  logic [3:0] frame_len;
  logic [55:0] frm;
  logic go;
  logic [7:0] err;

  mcri_reply_if rep();

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] chk(input logic [7:0] c,
                                     input logic [7:0] t,
                                     input logic [7:0] b);
    chk = STS_OK;
    case (c)
      ROTATE_CW_CMD, ROTATE_CCW_CMD, MOTOR_HALT_CMD, REF_SEARCH_CMD,
      AXIS_PARAM_WRITE, AXIS_PARAM_READ, ACCU_TO_AXIS_PARAM: begin
        if (b >= AXIS_COUNT) begin
          chk = STS_BAD_VALUE;
        end
      end
      MOVE_TO_TARGET_CMD: begin
        if (t > STORED_POINT_TARGET) begin
          chk = STS_BAD_TYPE;
        end else if (b >= AXIS_COUNT) begin
          chk = STS_BAD_VALUE;
        end
      end
      GLOBAL_PARAM_SAVE, GLOBAL_PARAM_RELOAD: begin
        if (b != USER_VAR_BANK) begin
          chk = STS_BAD_VALUE;
        end
      end
      ACCU_CONST_OP, ACCU_XREG_OP: begin
        if (t > OP_LOAD || (t > OP_MUL && t < OP_AND)) begin
          chk = STS_BAD_TYPE;
        end
      end
      BRANCH_IF: begin
        if (t > CND_LE) begin
          chk = STS_BAD_TYPE;
        end
      end
      CALL_CMD, RETURN_CMD: chk = STS_NOT_AVAIL;
      GLOBAL_PARAM_WRITE, GLOBAL_PARAM_READ, OUTPUT_WRITE_CMD,
      INPUT_READ_CMD, COMPARE_CMD, BRANCH_ALWAYS, WAIT_CMD, END_CMD,
      INT_ON_CMD, INT_OFF_CMD, POINT_SET_CMD, POINT_GET_CMD,
      POINT_CAPT_CMD, ACCU_TO_GLOBAL_PARAM, FLAG_CLR_CMD, VEC_SET_CMD,
      INT_RET_CMD, ACCU_TO_POINT_CMD: chk = STS_OK;
      default: chk = STS_BAD_CMD;
    endcase
  endfunction

  function automatic logic is_internal(input logic [7:0] c,
                                       input logic [7:0] t);
    is_internal = (c == ACCU_CONST_OP) || (c == ACCU_XREG_OP) ||
                  (c == COMPARE_CMD) || (c == BRANCH_IF) ||
                  (c == BRANCH_ALWAYS) || (c == END_CMD) ||
                  (c == WAIT_CMD && t == WAIT_TICKS);
  endfunction

  function automatic logic is_read(input logic [7:0] c);
    is_read = (c == AXIS_PARAM_READ) || (c == GLOBAL_PARAM_READ) ||
              (c == INPUT_READ_CMD) || (c == POINT_GET_CMD);
  endfunction

  function automatic logic [31:0] alu(input logic [7:0] op,
                                      input logic [31:0] a,
                                      input logic [31:0] b);
    case (op)
      OP_ADD: alu = a + b;
      OP_SUB: alu = a - b;
      OP_MUL: alu = a * b;
      OP_AND: alu = a & b;
      OP_OR: alu = a | b;
      OP_XOR: alu = a ^ b;
      OP_NOT: alu = ~a;
      OP_LOAD: alu = b;
      default: alu = a;
    endcase
  endfunction

  function automatic logic cond_met(input logic [7:0] t,
                                    input logic [31:0] a,
                                    input logic eq,
                                    input logic lt);
    case (t)
      CND_ZERO: cond_met = (a == RESET_WORD);
      CND_NZERO: cond_met = (a != RESET_WORD);
      CND_EQ: cond_met = eq;
      CND_NE: cond_met = !eq;
      CND_GT: cond_met = !eq && !lt;
      CND_GE: cond_met = !lt;
      CND_LT: cond_met = lt;
      CND_LE: cond_met = lt || eq;
      default: cond_met = 1'b0;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.rep_start = 1'b0;
    go = 1'b0;
    err = STS_OK;
    frame_len = can_mode ? FRAME_LEN_CAN : FRAME_LEN_SERIAL;
    frm = can_mode ? s_r.rx_buf[55:0] : s_r.rx_buf[63:8];

    // Frame collection
    if (rx_valid && !s_r.frm_rdy) begin
      s_nxt.rx_buf = {s_r.rx_buf[63:0], rx_data};
      if (s_r.rx_cnt == frame_len - 4'h1) begin
        s_nxt.frm_rdy = 1'b1;
        s_nxt.rx_ok = (s_r.rx_sum == rx_data);
        s_nxt.rx_cnt = 4'h0;
        s_nxt.rx_sum = RESET_BYTE;
      end else begin
        s_nxt.rx_cnt = s_r.rx_cnt + 4'h1;
        s_nxt.rx_sum = s_r.rx_sum + rx_data;
      end
    end

    // Tick wait of a running program
    if (s_r.wait_on && tick_pulse) begin
      s_nxt.wait_cnt = s_r.wait_cnt - 32'h1;
      if (s_r.wait_cnt <= 32'h1) begin
        s_nxt.wait_on = 1'b0;
      end
    end

    // Program control
    if (!download_mode) begin
      s_nxt.wptr = 5'h0;
      if (run_start) begin
        s_nxt.run_on = 1'b1;
        s_nxt.pc = 4'h0;
        s_nxt.wait_on = 1'b0;
      end
    end else begin
      s_nxt.run_on = 1'b0;
    end

    unique case (s_r.st)
      ST_IDLE: begin
        if (s_r.frm_rdy) begin
          s_nxt.frm_rdy = 1'b0;
          {s_nxt.cmd, s_nxt.typ, s_nxt.bank, s_nxt.val} = frm;
          s_nxt.from_prog = 1'b0;
          s_nxt.rval = frm[31:0];
          if (!can_mode && s_r.rx_buf[71:64] != module_addr) begin
            s_nxt.status = s_r.status;
          end else if (!can_mode && !s_r.rx_ok) begin
            s_nxt.status = STS_BAD_SUM;
            s_nxt.rep_start = 1'b1;
            s_nxt.st = ST_REPLY;
          end else if (download_mode) begin
            err = chk(frm[55:48], frm[47:40], frm[39:32]);
            if (err == STS_BAD_CMD) begin
              s_nxt.status = err;
            end else if (s_r.wptr == PROG_DEPTH) begin
              s_nxt.status = STS_BAD_VALUE;
            end else begin
              s_nxt.prog[s_r.wptr[3:0]] = frm;
              s_nxt.wptr = s_r.wptr + 5'h1;
              s_nxt.status = STS_STORED;
            end
            s_nxt.rep_start = 1'b1;
            s_nxt.st = ST_REPLY;
          end else begin
            go = 1'b1;
          end
        end else if (s_r.run_on && !s_r.wait_on && !download_mode) begin
          {s_nxt.cmd, s_nxt.typ, s_nxt.bank, s_nxt.val} = s_r.prog[s_r.pc];
          s_nxt.from_prog = 1'b1;
          s_nxt.pc = s_r.pc + 4'h1;
          go = 1'b1;
        end

        if (go) begin
          err = chk(s_nxt.cmd, s_nxt.typ, s_nxt.bank);
          s_nxt.rval = s_nxt.val;
          s_nxt.status = STS_OK;
          if (s_nxt.cmd == ACCU_TO_AXIS_PARAM ||
              s_nxt.cmd == ACCU_TO_GLOBAL_PARAM) begin
            s_nxt.ex_val = s_r.accu;
          end else begin
            s_nxt.ex_val = s_nxt.val;
          end
          if (err != STS_OK) begin
            s_nxt.status = err;
            if (s_nxt.from_prog) begin
              s_nxt.run_on = 1'b0;
            end
          end else if (is_internal(s_nxt.cmd, s_nxt.typ)) begin
            case (s_nxt.cmd)
              ACCU_CONST_OP: begin
                s_nxt.accu = alu(s_nxt.typ, s_r.accu, s_nxt.val);
                s_nxt.rval = s_nxt.accu;
              end
              ACCU_XREG_OP: begin
                if (s_nxt.typ == OP_LOAD) begin
                  s_nxt.xreg = s_r.accu;
                end else begin
                  s_nxt.accu = alu(s_nxt.typ, s_r.accu, s_r.xreg);
                end
                s_nxt.rval = s_nxt.accu;
              end
              COMPARE_CMD: begin
                s_nxt.flag_eq = (s_r.accu == s_nxt.val);
                s_nxt.flag_lt = $signed(s_r.accu) < $signed(s_nxt.val);
              end
              BRANCH_IF: begin
                if (cond_met(s_nxt.typ, s_r.accu, s_r.flag_eq,
                             s_r.flag_lt)) begin
                  s_nxt.pc = s_nxt.val[3:0];
                end
              end
              BRANCH_ALWAYS: s_nxt.pc = s_nxt.val[3:0];
              WAIT_CMD: begin
                if (s_nxt.from_prog && s_nxt.val != RESET_WORD) begin
                  s_nxt.wait_on = 1'b1;
                  s_nxt.wait_cnt = s_nxt.val;
                end
              end
              default: s_nxt.run_on = 1'b0;
            endcase
          end else begin
            s_nxt.exec_req = 1'b1;
            s_nxt.st = ST_EXEC;
          end
          if (!s_nxt.from_prog && s_nxt.st == ST_IDLE) begin
            s_nxt.rep_start = 1'b1;
            s_nxt.st = ST_REPLY;
          end
        end
      end
      ST_EXEC: begin
        if (exec_done) begin
          s_nxt.exec_req = 1'b0;
          if (s_r.from_prog) begin
            s_nxt.st = ST_IDLE;
            if (exec_status != STS_OK) begin
              s_nxt.run_on = 1'b0;
            end else if (is_read(s_r.cmd)) begin
              s_nxt.accu = exec_rdata;
            end
          end else begin
            s_nxt.status = exec_status;
            s_nxt.rval = exec_rdata;
            s_nxt.rep_start = 1'b1;
            s_nxt.st = ST_REPLY;
          end
        end
      end
      ST_REPLY: begin
        if (!s_r.rep_start && !rep.busy) begin
          s_nxt.st = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Reply transmitter
  // ----------------------------------------------------------------
  assign rep.start = s_r.rep_start;
  assign rep.can_mode = can_mode;
  assign rep.reply_addr = reply_addr;
  assign rep.module_addr = module_addr;
  assign rep.status = s_r.status;
  assign rep.cmd = s_r.cmd;
  assign rep.value = s_r.rval;

  mcri_reply_tx u_tx (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .rep(rep),
    .tx_data(tx_data),
    .tx_valid(tx_valid),
    .tx_ready(tx_ready)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign exec_req = s_r.exec_req;
  assign exec_cmd = s_r.cmd;
  assign exec_type = s_r.typ;
  assign exec_bank = s_r.bank;
  assign exec_value = s_r.ex_val;
  assign exec_from_prog = s_r.from_prog;
  assign run_active = s_r.run_on;

endmodule
`default_nettype wire

//--- tb/mcri_props.sv
`timescale 1ns/1ps
`default_nettype none
module mcri_props (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic can_mode,
  input wire logic [7:0] module_addr,
  input wire logic exec_req,
  input wire logic [7:0] exec_cmd,
  input wire logic exec_from_prog,
  input wire logic exec_done
);
  logic [3:0] cnt_r;
  logic [7:0] sum_r;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  // ----------------------------------------------------------------
  // Reply byte count and running sum
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      {cnt_r, sum_r} <= 12'h000;
    end else if (!tx_valid) begin
      {cnt_r, sum_r} <= 12'h000;
    end else if (tx_ready) begin
      cnt_r <= cnt_r + 4'h1;
      sum_r <= sum_r + tx_data;
    end
  end
  chk_tx_hold: assert property (
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("reply byte not held");
  chk_addr_byte: assert property (
    tx_valid && cnt_r == (can_mode ? 4'h0 : 4'h1) |-> tx_data == module_addr)
    else $error("module address byte wrong");
  chk_sum_byte: assert property (
    tx_valid && !can_mode && cnt_r == 4'h8 |-> tx_data == sum_r)
    else $error("reply checksum wrong");
  chk_frame_len: assert property (
    tx_valid |-> cnt_r < (can_mode ? 4'h7 : 4'h9))
    else $error("reply too long");
  chk_req_hold: assert property (
    exec_req && !exec_done |=> exec_req && $stable(exec_cmd))
    else $error("request not held");
  chk_req_drop: assert property (
    exec_req && exec_done |=> !exec_req)
    else $error("request not released");
  chk_exec_reply: assert property (
    exec_req && exec_done && !exec_from_prog |-> ##[1:4] tx_valid)
    else $error("no reply after execution");
  chk_quiet_exec: assert property (
    exec_req && !exec_from_prog |-> !tx_valid)
    else $error("transmit during execution");
endmodule
`default_nettype wire

//--- tb/mcri_host.sv
`timescale 1ns/1ps
`default_nettype none
module mcri_host (
  input wire logic clk_sys,
  output logic [7:0] rx_data,
  output logic rx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready
);
  int seed = 32'ha654dc72;
  logic [7:0] rq[$];
  initial begin
    rx_data = 8'h00;
    rx_valid = 1'b0;
  end
  // Random stalls on the reply side
  always @(negedge clk_sys) tx_ready <= ($random(seed) % 4) != 0;
  always @(posedge clk_sys) if (tx_valid && tx_ready) rq.push_back(tx_data);
  // One frame, value MSB first, line inverted when idle
  task automatic send(input logic [7:0] f[$]);
    foreach (f[k]) begin
      @(negedge clk_sys);
      rx_data = f[k];
      rx_valid = 1'b1;
    end
    @(negedge clk_sys);
    rx_data = ~rx_data;
    rx_valid = 1'b0;
  endtask
endmodule
`default_nettype wire

//--- tb/mcri_cmd_interp_test.sv
`timescale 1ns/1ps
`default_nettype none
module mcri_cmd_interp_test;
  import mcri_pkg::*;
  logic clk_sys = 0, rst_b = 0, can_mode = 0, download_mode = 0;
  logic run_start = 0, tick_pulse = 0, exec_done = 0, rx_valid, tx_valid;
  logic tx_ready, exec_req, exec_from_prog, run_active;
  logic [7:0] rx_data, tx_data, exec_cmd, exec_type, exec_bank, a, c, t, b, d;
  logic [7:0] module_addr = 8'h2c, reply_addr = 8'h02, exec_status = 8'h64;
  logic [7:0] st;
  logic [31:0] exec_value, exec_rdata = 0, accu = 0, v;
  logic [56:0] cap;
  int n_errors = 0, checks_done = 0, seed = 32'ha654dc72, n_ex = 0, n, i;
  logic [7:0] ops[8] = '{8'h09, 8'h00, 8'h01, 8'h02, 8'h05, 8'h06, 8'h07,
                         8'h08};
  logic [7:0] xc[10] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h09,
                         8'h0a, 8'h0e, 8'h0f};
  logic [47:0] er[7] = '{48'h00_07_00_00_00_02, 48'h00_13_03_00_00_03,
    48'h00_06_00_06_00_04, 48'h00_0b_00_00_00_04, 48'h00_17_00_00_00_06,
    48'h00_06_00_00_01_01, 48'h01_06_00_00_00_64};
  always #25 clk_sys = ~clk_sys;
  mcri_cmd_interp mcri_cmd_interp_inst (
    .clk_sys(clk_sys), .rst_b(rst_b), .rx_data(rx_data), .rx_valid(rx_valid),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .can_mode(can_mode), .module_addr(module_addr), .reply_addr(reply_addr),
    .download_mode(download_mode), .run_start(run_start),
    .tick_pulse(tick_pulse), .exec_req(exec_req), .exec_cmd(exec_cmd),
    .exec_type(exec_type), .exec_bank(exec_bank), .exec_value(exec_value),
    .exec_from_prog(exec_from_prog), .exec_done(exec_done),
    .exec_status(exec_status), .exec_rdata(exec_rdata),
    .run_active(run_active)
  );
  mcri_host host (.*);
  // ----------------------------------------------------------------
  // Executor: answers one cycle after each request
  // ----------------------------------------------------------------
  always @(negedge clk_sys) begin
    exec_done <= exec_req && !exec_done;
    if (exec_req && !exec_done) begin
      cap <= {exec_from_prog, exec_cmd, exec_type, exec_bank, exec_value};
      exec_rdata <= exec_cmd inside {8'h06, 8'h0a, 8'h0f} ? $random(seed) :
                    exec_value;
      n_ex <= n_ex + 1;
    end
  end
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d, mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic cmd(input logic [7:0] a, c, t, b, input logic [31:0] v,
                     input logic [7:0] d, st, input logic [31:0] rv,
                     input bit rep, x);
    logic [7:0] f[$], e[$], s;
    int i, m;
    f = {a, c, t, b, v[31:24], v[23:16], v[15:8], v[7:0]};
    if (can_mode) void'(f.pop_front());
    s = 8'h00;
    foreach (f[k]) s += f[k];
    if (!can_mode) f.push_back(s + d);
    host.rq.delete();
    host.send(f);
    m = rep ? (can_mode ? 7 : 9) : 0;
    for (i = 0; i < 30 || host.rq.size() < m; i++) begin
      if (i == 300) begin
        n_errors++;
        break;
      end
      @(negedge clk_sys);
    end
    if (x) rv = exec_rdata;
    e = {reply_addr, module_addr, st, c, rv[31:24], rv[23:16], rv[15:8],
         rv[7:0]};
    if (can_mode) void'(e.pop_front());
    s = 8'h00;
    foreach (e[k]) s += e[k];
    if (!can_mode) e.push_back(s);
    chk(host.rq.size(), m);
    for (i = 0; i < m; i++) chk(host.rq[i], e[i]);
  endtask
  task automatic ext(input logic [7:0] c);
    logic [31:0] v;
    logic [7:0] t, b;
    int n;
    v = $random(seed);
    t = 8'($unsigned($random(seed)) % 3);
    b = 8'($unsigned($random(seed)) % 6);
    n = n_ex;
    cmd(module_addr, c, t, b, v, 8'h00, exec_status, v, 1'b1, 1'b1);
    chk(cap, {1'b0, c, t, b, v});
    chk(n_ex, n + 1);
  endtask
  initial begin
    repeat (8) @(negedge clk_sys);
    rst_b = 1'b1;
    foreach (xc[k]) ext(xc[k]);
    exec_status = STS_LOCKED;
    ext(GLOBAL_PARAM_WRITE);
    exec_status = STS_OK;
    can_mode = 1'b1;
    ext(INPUT_READ_CMD);
    can_mode = 1'b0;
    $display("external commands done");
    foreach (ops[k]) begin
      v = $random(seed);
      case (ops[k])
        OP_LOAD: accu = v;
        OP_ADD: accu = accu + v;
        OP_SUB: accu = accu - v;
        OP_MUL: accu = accu * v;
        OP_AND: accu = accu & v;
        OP_OR: accu = accu | v;
        OP_XOR: accu = accu ^ v;
        default: accu = ~accu;
      endcase
      cmd(module_addr, ACCU_CONST_OP, ops[k], 8'h00, v, 8'h00, STS_OK, accu,
          1'b1, 1'b0);
    end
    cmd(module_addr, ACCU_XREG_OP, OP_LOAD, 8'h00, v, 8'h00, STS_OK, accu,
        1'b1, 1'b0);
    accu = accu + accu;
    cmd(module_addr, ACCU_XREG_OP, OP_ADD, 8'h00, v, 8'h00, STS_OK, accu,
        1'b1, 1'b0);
    cmd(module_addr, ACCU_TO_AXIS_PARAM, 8'h00, 8'h01, v, 8'h00, STS_OK, accu,
        1'b1, 1'b0);
    chk(cap, {1'b0, ACCU_TO_AXIS_PARAM, 8'h00, 8'h01, accu});
    $display("accumulator commands done");
    n = n_ex;
    foreach (er[k]) begin
      {a, c, t, b, d, st} = er[k];
      cmd(module_addr ^ a, c, t, b, accu, d, st, accu, a == 8'h00,
          1'b0);
    end
    chk(n_ex, n);
    $display("error replies done");
    download_mode = 1'b1;
    cmd(module_addr, ROTATE_CW_CMD, 8'h00, 8'h01, v, 8'h00, STS_STORED, v,
        1'b1, 1'b0);
    cmd(module_addr, WAIT_CMD, WAIT_TICKS, 8'h00, 32'h2, 8'h00, STS_STORED,
        32'h2, 1'b1, 1'b0);
    cmd(module_addr, END_CMD, 8'h00, 8'h00, v, 8'h00, STS_STORED, v, 1'b1,
        1'b0);
    download_mode = 1'b0;
    run_start = 1'b1;
    @(negedge clk_sys);
    run_start = 1'b0;
    for (i = 0; i < 200 && (run_active !== 1'b0 || n_ex == n); i++) begin
      tick_pulse = 1'($random(seed));
      @(negedge clk_sys);
    end
    tick_pulse = 1'b0;
    if (i == 200) n_errors++;
    chk(n_ex, n + 1);
    chk(cap, {1'b1, ROTATE_CW_CMD, 8'h00, 8'h01, v});
    chk(run_active, 1'b0);
    chk(host.rq.size(), 9);
    $display("stored program done");
    print_verdict();
  end
endmodule
bind mcri_cmd_interp mcri_props mcri_props_inst (
  .clk_sys(clk_sys), .rst_b(rst_b), .tx_data(tx_data), .tx_valid(tx_valid),
  .tx_ready(tx_ready), .can_mode(can_mode), .module_addr(module_addr),
  .exec_req(exec_req), .exec_cmd(exec_cmd), .exec_from_prog(exec_from_prog),
  .exec_done(exec_done)
);
`default_nettype wire
